//--- src/mwsod_decoder.v
// Purpose: decode and execute the special-operation field of a microinstruction
// Assumes: one microinstruction per clock while running; memory resume and start from pins
// Notes: stall holds the sequencer; field decode outputs registered per microinstruction
`timescale 1ns/1ns
`include "mwsod_map.vh"
module mwsod_decoder (
   input wire clock,
   input wire resetn,
   input wire instr_valid,
   input wire [3:0] special_op,
   input wire [15:0] current_pair_addr,
   input wire [15:0] normal_next_addr,
   input wire [31:0] alu_result,
   input wire [31:0] first_shifter_stage,
   input wire [31:0] f_reg,
   input wire [15:0] mode_flag_register,
   input wire addr_load,
   input wire [15:0] addr_load_value,
   input wire count_load,
   input wire [7:0] count_load_value,
   input wire page_load,
   input wire [7:0] page_load_value,
   input wire [7:0] file_read_index,
   input wire mem_resume_pin,
   input wire start_pin,
   output reg stall,
   output reg halted,
   output reg [15:0] next_pair_addr,
   output reg [15:0] memory_address_buffer,
   output reg mem_read_req,
   output reg mem_write_req,
   output reg [31:0] mem_write_data,
   output reg [31:0] third_shifter_stage,
   output reg [31:0] instr_reg,
   output reg [15:0] return_jump_reg,
   output reg [7:0] repeat_count,
   output reg [7:0] page_reg,
   output reg [31:0] file_read_data,
   output reg alt_a_coding,
   output reg alt_b_coding,
   output reg [1:0] alt_dest_sel
);
   reg [31:0] second_file [0:255];
   reg [1:0] state;
   reg [1:0] next_state;
   reg addr_pending;
   reg [15:0] addr_pending_value;
   reg [31:0] next_shift_out;
   reg [15:0] next_addr;
   reg [1:0] next_dest;
   reg next_alt_a;
   reg next_alt_b;
   wire resume;
   wire start;
   wire take;
   wire mem_op;
   wire mem_done;
   wire do_read;
   wire do_write;
   wire do_halt;
   wire do_file_write;
   wire resume_rise;
   wire start_rise;
   reg resume_prev;
   reg start_prev;

   // Sequencer states
   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_MEM_WAIT = 2'h1;
   localparam [1:0] ST_HALTED = 2'h2;

   mwsod_sync u_resume (
      .clock(clock),
      .resetn(resetn),
      .d(mem_resume_pin),
      .q(resume)
   );
   mwsod_sync u_start (
      .clock(clock),
      .resetn(resetn),
      .d(start_pin),
      .q(start)
   );

   // End-around: the top byte wraps to the bottom
   function [31:0] rotl8;
      input [31:0] v;
      begin
         rotl8 = {v[31-`MWSOD_ROT_BITS:0], v[31:32-`MWSOD_ROT_BITS]};
      end
   endfunction

   function is_mem;
      input [3:0] op;
      begin
         is_mem = (op == `MWSOD_OP_READ) || (op == `MWSOD_OP_WRITE);
      end
   endfunction

   // Repeat test shared by pair selection and count update
   function count_nonzero;
      input [7:0] n;
      begin
         count_nonzero = (n != `MWSOD_COUNT_RESET);
      end
   endfunction

   assign take = instr_valid && (state == ST_RUN);
   assign mem_op = take && is_mem(special_op);
   // Resume and start act on their rising edge: a level still high from the
   // previous command or restart must not end the next wait
   assign resume_rise = resume && !resume_prev;
   assign start_rise = start && !start_prev;
   assign mem_done = (state == ST_MEM_WAIT) && resume_rise;
   assign do_read = take && (special_op == `MWSOD_OP_READ);
   assign do_write = take && (special_op == `MWSOD_OP_WRITE);
   assign do_halt = take && (special_op == `MWSOD_OP_HALT) &&
                    mode_flag_register[`MWSOD_HALT_BIT];
   assign do_file_write = take && (special_op == `MWSOD_OP_SECOND_FILE_WRITE);

   // Field decode, one operation per microinstruction
   always @* begin
      next_shift_out = alu_result;
      next_addr = normal_next_addr;
      next_dest = `MWSOD_DEST_NORMAL;
      next_alt_a = 1'b0;
      next_alt_b = 1'b0;
      case (special_op)
         `MWSOD_OP_NOP: begin
            next_dest = `MWSOD_DEST_NORMAL;
         end
         `MWSOD_OP_ALT_DEST_DOUBLE: begin
            next_dest = `MWSOD_DEST_DOUBLE;
         end
         `MWSOD_OP_ALT_DEST: begin
            next_dest = `MWSOD_DEST_PRIME;
         end
         `MWSOD_OP_ALT_DEST_SECOND: begin
            next_dest = `MWSOD_DEST_SECOND;
         end
         `MWSOD_OP_ALT_A: begin
            next_alt_a = 1'b1;
         end
         `MWSOD_OP_ALT_B: begin
            next_alt_b = 1'b1;
         end
         `MWSOD_OP_ALT_A_AND_DEST: begin
            next_alt_a = 1'b1;
            next_dest = `MWSOD_DEST_PRIME;
         end
         `MWSOD_OP_REPEAT_PAIR: begin
            if (count_nonzero(repeat_count)) begin
               next_addr = current_pair_addr;
            end else begin
               next_addr = normal_next_addr;
            end
         end
         `MWSOD_OP_ROTATE_LEFT_BYTE: begin
            next_shift_out = rotl8(alu_result);
         end
         default: begin
            next_shift_out = alu_result;
         end
      endcase
   end

   // Sequencer: run, wait for memory, halted
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (mem_op) begin
               next_state = ST_MEM_WAIT;
            end else if (do_halt) begin
               next_state = ST_HALTED;
            end
         end
         ST_MEM_WAIT: begin
            if (mem_done) begin
               next_state = ST_RUN;
            end
         end
         ST_HALTED: begin
            if (start_rise) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // Sequencer registers; stall and halted follow the state being entered
   always @(posedge clock) begin
      if (!resetn) begin
         state <= ST_RUN;
         stall <= 1'b0;
         halted <= 1'b0;
         resume_prev <= 1'b0;
         start_prev <= 1'b0;
      end else begin
         state <= next_state;
         stall <= (next_state != ST_RUN);
         halted <= (next_state == ST_HALTED);
         resume_prev <= resume;
         start_prev <= start;
      end
   end

   // Memory interface: requests stay up until the memory answers
   always @(posedge clock) begin
      if (!resetn) begin
         memory_address_buffer <= `MWSOD_ADDR_RESET;
         addr_pending <= 1'b0;
         addr_pending_value <= `MWSOD_ADDR_RESET;
         mem_read_req <= 1'b0;
         mem_write_req <= 1'b0;
         mem_write_data <= `MWSOD_DATA_RESET;
      end else begin
         if (mem_done) begin
            mem_read_req <= 1'b0;
            mem_write_req <= 1'b0;
            if (addr_pending) begin
               memory_address_buffer <= addr_pending_value;
               addr_pending <= 1'b0;
            end
         end
         // Reload during a memory op waits so the running cycle keeps its address
         if (take && addr_load) begin
            if (mem_op) begin
               addr_pending <= 1'b1;
               addr_pending_value <= addr_load_value;
            end else begin
               memory_address_buffer <= addr_load_value;
            end
         end
         if (do_read) begin
            mem_read_req <= 1'b1;
         end
         if (do_write) begin
            mem_write_req <= 1'b1;
            mem_write_data <= next_shift_out;
         end
      end
   end

   // Field outputs and next pair, held until the next microinstruction
   always @(posedge clock) begin
      if (!resetn) begin
         next_pair_addr <= `MWSOD_ADDR_RESET;
         third_shifter_stage <= `MWSOD_DATA_RESET;
         alt_a_coding <= 1'b0;
         alt_b_coding <= 1'b0;
         alt_dest_sel <= `MWSOD_DEST_NORMAL;
      end else if (take) begin
         third_shifter_stage <= next_shift_out;
         alt_a_coding <= next_alt_a;
         alt_b_coding <= next_alt_b;
         alt_dest_sel <= next_dest;
         next_pair_addr <= next_addr;
      end
   end

   // Count and page; the operation wins over a load in the same microinstruction
   always @(posedge clock) begin
      if (!resetn) begin
         repeat_count <= `MWSOD_COUNT_RESET;
         page_reg <= `MWSOD_PAGE_RESET;
      end else if (take) begin
         if (count_load) begin
            repeat_count <= count_load_value;
         end
         if (page_load) begin
            page_reg <= page_load_value;
         end
         case (special_op)
            `MWSOD_OP_REPEAT_PAIR: begin
               if (count_nonzero(repeat_count)) begin
                  repeat_count <= repeat_count - 8'h01;
               end
            end
            `MWSOD_OP_CLEAR_COUNT_PAGE: begin
               repeat_count <= `MWSOD_COUNT_RESET;
               page_reg <= `MWSOD_PAGE_RESET;
            end
            default: begin
            end
         endcase
      end
   end

   // Instruction register and return address
   always @(posedge clock) begin
      if (!resetn) begin
         instr_reg <= `MWSOD_DATA_RESET;
         return_jump_reg <= `MWSOD_ADDR_RESET;
      end else if (take) begin
         case (special_op)
            `MWSOD_OP_LOAD_INSTR_REG: begin
               instr_reg <= first_shifter_stage;
            end
            `MWSOD_OP_RETURN_JUMP: begin
               return_jump_reg <= current_pair_addr + 16'h0001;
            end
            default: begin
               instr_reg <= instr_reg;
            end
         endcase
      end
   end

   // Second file: written at the count held when the microinstruction starts
   always @(posedge clock) begin
      if (do_file_write) begin
         second_file[repeat_count] <= f_reg;
      end
   end

   // Read port, one cycle late and without reset
   always @(posedge clock) begin
      file_read_data <= second_file[file_read_index];
   end
endmodule

//--- src/mwsod_map.vh
// Purpose: constants for the special-operation decoder
// Assumes: 4-bit special-operation field, 32-bit data path
// Notes: codes as printed for the field
`ifndef MWSOD_MAP_VH
`define MWSOD_MAP_VH
`define MWSOD_OP_NOP 4'h0
`define MWSOD_OP_ALT_DEST_DOUBLE 4'h1
`define MWSOD_OP_REPEAT_PAIR 4'h2
`define MWSOD_OP_READ 4'h3
`define MWSOD_OP_WRITE 4'h4
`define MWSOD_OP_ROTATE_LEFT_BYTE 4'h5
`define MWSOD_OP_SECOND_FILE_WRITE 4'h6
`define MWSOD_OP_ALT_A 4'h7
`define MWSOD_OP_ALT_B 4'h8
`define MWSOD_OP_ALT_DEST 4'h9
`define MWSOD_OP_ALT_A_AND_DEST 4'hA
`define MWSOD_OP_ALT_DEST_SECOND 4'hB
`define MWSOD_OP_LOAD_INSTR_REG 4'hC
`define MWSOD_OP_HALT 4'hD
`define MWSOD_OP_RETURN_JUMP 4'hE
`define MWSOD_OP_CLEAR_COUNT_PAGE 4'hF
`define MWSOD_DEST_NORMAL 2'h0
`define MWSOD_DEST_PRIME 2'h1
`define MWSOD_DEST_DOUBLE 2'h2
`define MWSOD_DEST_SECOND 2'h3
`define MWSOD_ROT_BITS 8
`define MWSOD_COUNT_RESET 8'h00
`define MWSOD_PAGE_RESET 8'h00
`define MWSOD_ADDR_RESET 16'h0000
`define MWSOD_HALT_BIT 0
`define MWSOD_DATA_RESET 32'h00000000
`endif

//--- src/mwsod_sync.v
// Purpose: two-flop synchroniser for pin levels
// Assumes: one clock
// Notes: first stage read only by the second
`timescale 1ns/1ns
module mwsod_sync (
   input wire clock,
   input wire resetn,
   input wire d,
   output reg q
);
   reg meta;
   always @(posedge clock) begin
      if (!resetn) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

//--- dv/mwsod_decoder_props.sv
// Purpose: port assertions for the special-operation decoder
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ns
module mwsod_decoder_props (
   input wire clock,
   input wire resetn,
   input wire instr_valid,
   input wire [3:0] special_op,
   input wire [15:0] current_pair_addr,
   input wire [15:0] normal_next_addr,
   input wire [31:0] alu_result,
   input wire [31:0] first_shifter_stage,
   input wire [15:0] mode_flag_register,
   input wire stall,
   input wire halted,
   input wire [15:0] next_pair_addr,
   input wire mem_read_req,
   input wire mem_write_req,
   input wire [31:0] mem_write_data,
   input wire [31:0] third_shifter_stage,
   input wire [31:0] instr_reg,
   input wire [15:0] return_jump_reg,
   input wire [7:0] repeat_count,
   input wire [7:0] page_reg
);
   wire tk = instr_valid && !stall;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   repeat_dec_a: assert property (
      tk && special_op == 4'h2 && repeat_count != 8'h00 |=> repeat_count ==
      $past(repeat_count) - 8'h01 && next_pair_addr == $past(current_pair_addr))
      else $error("repeat did not re-execute pair");
   repeat_zero_a: assert property (
      tk && special_op == 4'h2 && repeat_count == 8'h00 |=>
      next_pair_addr == $past(normal_next_addr)) else $error("repeat at zero");
   mem_stall_a: assert property (
      tk && (special_op == 4'h3 || special_op == 4'h4) |=> stall && !halted)
      else $error("memory op did not stall");
   read_req_a: assert property (
      tk && special_op == 4'h3 |=> mem_read_req && !mem_write_req)
      else $error("read request missing");
   write_data_a: assert property (
      tk && special_op == 4'h4 |=> mem_write_req && mem_write_data == $past(alu_result))
      else $error("write data wrong");
   rotate_byte_a: assert property (
      tk && special_op == 4'h5 |=> third_shifter_stage ==
      {$past(alu_result[23:0]), $past(alu_result[31:24])}) else $error("rotate wrong");
   load_ir_a: assert property (
      tk && special_op == 4'hC |=> instr_reg == $past(first_shifter_stage))
      else $error("instruction register not loaded");
   halt_stop_a: assert property (
      tk && special_op == 4'hD && mode_flag_register[0] |=> halted && stall)
      else $error("halt not taken");
   return_jump_a: assert property (
      tk && special_op == 4'hE |=> return_jump_reg == $past(current_pair_addr) + 16'h0001)
      else $error("return address wrong");
   clear_np_a: assert property (
      tk && special_op == 4'hF |=> repeat_count == 8'h00 && page_reg == 8'h00)
      else $error("count or page not cleared");
endmodule
bind mwsod_decoder mwsod_decoder_props i_props (.clock, .resetn, .instr_valid, .special_op,
   .current_pair_addr, .normal_next_addr, .alu_result, .first_shifter_stage,
   .mode_flag_register, .stall, .halted, .next_pair_addr, .mem_read_req, .mem_write_req,
   .mem_write_data, .third_shifter_stage, .instr_reg, .return_jump_reg, .repeat_count,
   .page_reg);

//--- dv/mwsod_mem_model.sv
// Purpose: main memory answering requests with a resume level
// Assumes: requests are levels held until resume is seen
// Notes: resume drops once the request is gone
`timescale 1ns/1ns
module mwsod_mem_model #(
   parameter DELAY = 3
) (
   input wire clock,
   input wire read_req,
   input wire write_req,
   input wire [31:0] write_data,
   output reg resume
);
   integer wait_count = 0;
   reg [31:0] stored = 32'h00000000;
   initial resume = 1'b0;
   always @(posedge clock) begin
      if (!(read_req || write_req)) begin
         wait_count <= 0;
         resume <= 1'b0;
      end else if (wait_count >= DELAY) begin
         resume <= 1'b1;
         if (write_req) stored <= write_data;
      end else begin
         wait_count <= wait_count + 1;
      end
   end
endmodule

//--- dv/mwsod_decoder_tb.sv
// Purpose: self-checking bench for the special-operation decoder
// Assumes: memory model answers after a few cycles
// Notes: one task per scenario
`timescale 1ns/1ns
module mwsod_decoder_tb;
   reg clock = 0, resetn = 0, instr_valid = 0, addr_load = 0, count_load = 0;
   reg page_load = 0, start_pin = 0;
   reg [3:0] special_op = 4'h0;
   reg [15:0] current_pair_addr = 16'h0100, normal_next_addr = 16'h0200;
   reg [15:0] mode_flag_register = 16'h0000, addr_load_value = 16'h0000;
   reg [31:0] alu_result = 32'h12345678, first_shifter_stage = 32'hCAFE0001;
   reg [31:0] f_reg = 32'hDEADBEEF;
   reg [7:0] count_load_value = 8'h00, page_load_value = 8'h00, file_read_index = 8'h00;
   wire mem_resume_pin, stall, halted, mem_read_req, mem_write_req, alt_a_coding, alt_b_coding;
   wire [15:0] next_pair_addr, memory_address_buffer, return_jump_reg;
   wire [31:0] mem_write_data, third_shifter_stage, instr_reg, file_read_data;
   wire [7:0] repeat_count, page_reg;
   wire [1:0] alt_dest_sel;
   integer bad_count = 0, checks = 0, i;
   reg [7:0] tab [0:5];
   mwsod_decoder i_mwsod_decoder (.clock, .resetn, .instr_valid, .special_op,
      .current_pair_addr, .normal_next_addr, .alu_result, .first_shifter_stage, .f_reg,
      .mode_flag_register, .addr_load, .addr_load_value, .count_load, .count_load_value,
      .page_load, .page_load_value, .file_read_index, .mem_resume_pin, .start_pin, .stall,
      .halted, .next_pair_addr, .memory_address_buffer, .mem_read_req, .mem_write_req,
      .mem_write_data, .third_shifter_stage, .instr_reg, .return_jump_reg, .repeat_count,
      .page_reg, .file_read_data, .alt_a_coding, .alt_b_coding, .alt_dest_sel);
   mwsod_mem_model i_mwsod_mem_model (.clock, .read_req(mem_read_req),
      .write_req(mem_write_req), .write_data(mem_write_data), .resume(mem_resume_pin));
   initial forever #10 clock = ~clock;
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Present one microinstruction, then look just after the edge that takes it
   task issue(input [3:0] op);
      begin
         @(posedge clock);
         special_op <= op;
         instr_valid <= 1'b1;
         @(posedge clock);
         instr_valid <= 1'b0;
         addr_load <= 1'b0;
         count_load <= 1'b0;
         page_load <= 1'b0;
         #1;
      end
   endtask
   // Bounded wait for the sequencer, looking just after each edge
   task wait_run;
      begin
         for (i = 0; i < 40 && stall !== 1'b0; i = i + 1) begin
            @(posedge clock);
            #1;
         end
         chk(stall, 1'b0, "stall released");
      end
   endtask
   task s_repeat;
      begin
         count_load <= 1'b1;
         count_load_value <= 8'h02;
         issue(4'h0);
         chk(alt_dest_sel, 2'h0, "nop dest");
         issue(4'h2);
         chk({next_pair_addr, repeat_count}, 24'h010001, "repeat");
         issue(4'h2);
         issue(4'h2);
         chk({next_pair_addr, repeat_count}, 24'h020000, "repeat zero");
      end
   endtask
   task s_codings;
      begin
         tab[0] = 8'h12;
         tab[1] = 8'h78;
         tab[2] = 8'h84;
         tab[3] = 8'h91;
         tab[4] = 8'hA9;
         tab[5] = 8'hB3;
         for (i = 0; i < 6; i = i + 1) begin
            issue(tab[i][7:4]);
            chk({alt_a_coding, alt_b_coding, alt_dest_sel}, tab[i][3:0], "coding");
         end
      end
   endtask
   task s_memory;
      begin
         addr_load <= 1'b1;
         addr_load_value <= 16'h0040;
         issue(4'h0);
         addr_load <= 1'b1;
         addr_load_value <= 16'h0055;
         issue(4'h3);
         chk({mem_read_req, stall, memory_address_buffer}, 18'h30040, "read wait");
         wait_run;
         chk({mem_read_req, memory_address_buffer}, 17'h00055, "read done");
         addr_load <= 1'b1;
         addr_load_value <= 16'h0066;
         alu_result <= 32'hA5A5C3C3;
         issue(4'h4);
         chk({mem_write_req, stall, memory_address_buffer}, 18'h30055, "write wait");
         wait_run;
         chk(i_mwsod_mem_model.stored, 32'hA5A5C3C3, "stored data");
         chk(memory_address_buffer, 16'h0066, "write reload");
      end
   endtask
   task s_datapath;
      begin
         issue(4'h5);
         chk(third_shifter_stage, 32'hA5C3C3A5, "rotate");
         count_load <= 1'b1;
         count_load_value <= 8'h05;
         issue(4'h0);
         file_read_index <= 8'h05;
         issue(4'h6);
         @(posedge clock);
         #1;
         chk(file_read_data, 32'hDEADBEEF, "second file");
         chk(repeat_count, 8'h05, "count kept");
         issue(4'hC);
         chk(instr_reg, 32'hCAFE0001, "gate to I");
         current_pair_addr <= 16'h0123;
         issue(4'hE);
         chk(return_jump_reg, 16'h0124, "return jump");
         page_load <= 1'b1;
         page_load_value <= 8'h09;
         issue(4'h0);
         issue(4'hF);
         chk({repeat_count, page_reg}, 16'h0000, "clear");
      end
   endtask
   task s_halt;
      begin
         issue(4'hD);
         chk({halted, stall}, 2'h0, "halt bit clear");
         mode_flag_register <= 16'h0001;
         issue(4'hD);
         chk({halted, stall}, 2'h3, "halted");
         repeat (5) @(posedge clock);
         chk(halted, 1'b1, "still halted");
         current_pair_addr <= 16'h0300;
         issue(4'hE);
         chk(return_jump_reg, 16'h0124, "refused while halted");
         start_pin <= 1'b1;
         wait_run;
         chk(halted, 1'b0, "restarted");
         start_pin <= 1'b0;
      end
   endtask
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      #1;
      chk({stall, repeat_count}, 9'h000, "after reset");
      s_repeat;
      s_codings;
      s_memory;
      s_datapath;
      s_halt;
      test_done;
   end
   // Scenarios need well under a thousand cycles
   initial begin
      #100000;
      bad_count = bad_count + 1;
      test_done;
   end
endmodule
